// ### shared/i2cs_map.vh
// How it works
// - address match clears, data byte sets data flag
// - last start or stop condition wins flags
// - direction flag latched from address byte
// - receive full set on store, cleared on read
// - transmit full set on write, cleared when sent
// - ten-bit mask bits make address bits don't-care
// - seven-bit mask bit x covers address byte bit x+1
// - current source enable at bit 15, reset 0
// - output select decode, codes 101-111 reserved
// - enable activates master and slave together
// - enabling releases both bus lines idle
// - master idle until start request or transmit load
// - slave monitors bus, acts on start plus match
// - enabled block overrides pins unless preempted
// - three separate interrupt flags
// - master irq on start condition, bytes, ack, collision
// - slave irq on conditions, match, requests, data
// - collision irq on master or slave collisions
// - flags set regardless of irqen_q, request needs enable
// - slave start and stop irq enables
// - collision flag set on collision, cleared on disable
`ifndef I2CS_MAP_VH
`define I2CS_MAP_VH
`define I2CS_OFF_CTRL 12'h000
`define I2CS_OFF_STAT 12'h004
`define I2CS_OFF_MASK 12'h008
`define I2CS_OFF_ISRC 12'h00C
`define I2CS_OFF_TX 12'h010
`define I2CS_OFF_RX 12'h014
`define I2CS_OFF_ADDR 12'h018
`define I2CS_OFF_IRQ 12'h01C
`define I2CS_CTRL_EN 15
`define I2CS_CTRL_A10 10
`define I2CS_CTRL_PCIE 6
`define I2CS_CTRL_START_IRQ_EN 5
`define I2CS_CTRL_START_REQ 0
`define I2CS_ST_COLL 10
`define I2CS_ST_DA 5
`define I2CS_ST_P 4
`define I2CS_ST_S 3
`define I2CS_ST_RW 2
`define I2CS_ST_RX_FULL 1
`define I2CS_ST_TX_FULL 0
`define I2CS_ISRC_EN 15
`define I2CS_MASK_RST 16'h0000
`define I2CS_ISRC_RST 16'h0000
`define I2CS_ISRC_WMASK 16'h873F
`define I2CS_MASK_WMASK 16'h03FF
`define I2CS_BIT_TICKS 8'h32
`endif

// ### core/i2cs_core.v
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "i2cs_map.vh"
module i2cs_core (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire serial_clock_pin_i,
   output reg serial_clock_pin_o,
   output reg serial_clock_pin_oe,
   input wire serial_data_pin_i,
   output reg serial_data_pin_o,
   output reg serial_data_pin_oe,
   input wire pins_preempted,
   output reg master_event_irq,
   output reg slave_event_irq,
   output reg collision_irq,
   output reg current_source_enable,
   output reg [3:0] current_output_onehot,
   output reg [5:0] current_calibration
);
   localparam M_IDLE = 3'h0;
   localparam M_START = 3'h1;
   localparam M_BIT_LO = 3'h2;
   localparam M_BIT_HI = 3'h3;
   localparam M_DONE = 3'h4;

   reg [1:0] scl_s_q, sda_s_q;
   reg scl_p_q, sda_p_q;
   reg [15:0] ctrl_q, mask_q, isrc_q;
   reg [9:0] own_addr_q;
   reg [7:0] tx_q, rx_q, sh_q, msh_q;
   reg coll_flag_q, da_q, p_q, s_q, rw_q, rx_full_q, tx_full_q;
   reg [1:0] addr_hi_q;
   reg slave_ack_q;
   reg [2:0] irq_q, irqen_q;
   reg [3:0] bit_q, mbit_q;
   reg [1:0] byte_q;
   reg addressed_q, first_q, mdrive_q;
   reg [2:0] mst_q;
   reg [7:0] tick_q;
   reg sda_oe_q, scl_oe_q;

   wire en = ctrl_q[`I2CS_CTRL_EN];
   wire scl = scl_s_q[1];
   wire sda = sda_s_q[1];
   wire scl_rise = scl & ~scl_p_q;
   wire scl_fall = ~scl & scl_p_q;
   wire start_det = en & scl & scl_p_q & sda_p_q & ~sda;
   wire stop_det = en & scl & scl_p_q & ~sda_p_q & sda;
   wire wr = psel & penable & pwrite;
   wire rd = psel & penable & ~pwrite;
   wire busy = mst_q != M_IDLE;
   wire tx_wr = wr & (paddr == `I2CS_OFF_TX);
   wire rx_rd = rd & (paddr == `I2CS_OFF_RX);
   // after the eighth rise the shifter already holds the whole byte
   wire [7:0] rx_byte = sh_q;
   wire [7:0] sh_next = {sh_q[6:0], sda};
   wire a10 = ctrl_q[`I2CS_CTRL_A10];
   // masked compare; 7-bit mask bit x covers byte bit x+1
   wire [6:0] m7_miss = (rx_byte[7:1] ^ own_addr_q[6:0]) & ~mask_q[6:0];
   wire [9:0] m10_miss = ({addr_hi_q, rx_byte} ^ own_addr_q) & ~mask_q[9:0];
   wire gcall = ~a10 & (rx_byte == 8'h00);
   wire hi_ok = (rx_byte[7:3] == 5'h1E) & (((rx_byte[2:1] ^ own_addr_q[9:8]) & ~mask_q[9:8]) == 2'h0);
   wire match7 = ~a10 & ((m7_miss == 7'h00) | gcall);
   wire match10 = a10 & (byte_q == 2'h1) & (m10_miss == 10'h000);
   wire byte_end = en & scl_fall & (bit_q == 4'h8);
   wire slave_tx = addressed_q & rw_q;
   // collision: we release sda high but line reads low on scl rise
   wire coll = en & scl_rise & ~sda & ((mdrive_q & ~sda_oe_q) | (slave_tx & ~sda_oe_q & bit_q < 4'h8));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], serial_clock_pin_i};
         sda_s_q <= {sda_s_q[0], serial_data_pin_i};
         scl_p_q <= scl;
         sda_p_q <= sda;
      end
   end

   // register write strobes
   wire wr_ctrl = wr & (paddr == `I2CS_OFF_CTRL);
   wire wr_mask = wr & (paddr == `I2CS_OFF_MASK);
   wire wr_isrc = wr & (paddr == `I2CS_OFF_ISRC);
   wire wr_addr = wr & (paddr == `I2CS_OFF_ADDR);
   wire wr_irq = wr & (paddr == `I2CS_OFF_IRQ);
   wire tx_take = tx_wr & ~busy;
   // master receive is not built, so only the slave fills the holding register
   wire rx_store = byte_end & addressed_q & ~rw_q;
   wire addr_take = byte_end & ~addressed_q & (match7 | match10);
   wire hi_take = byte_end & a10 & (byte_q == 2'h0) & hi_ok;

   // control; start request self-clears once the start condition is on the bus
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 16'h0000;
      end else if (wr_ctrl) begin
         ctrl_q <= pwdata[15:0];
      end else if (mst_q == M_START && tick_q == 8'h00) begin
         ctrl_q[`I2CS_CTRL_START_REQ] <= 1'b0;
      end
   end

   // configuration registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= `I2CS_MASK_RST;
         isrc_q <= `I2CS_ISRC_RST;
         own_addr_q <= 10'h000;
         tx_q <= 8'h00;
      end else begin
         if (wr_mask) begin
            mask_q <= pwdata[15:0] & `I2CS_MASK_WMASK;
         end
         if (wr_isrc) begin
            isrc_q <= pwdata[15:0] & `I2CS_ISRC_WMASK;
         end
         if (wr_addr) begin
            own_addr_q <= pwdata[9:0];
         end
         // a load while the master shifts is dropped, not queued
         if (tx_take) begin
            tx_q <= pwdata[7:0];
         end
      end
   end

   // collision flag; cannot clash with the clear, coll needs enable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coll_flag_q <= 1'b0;
      end else if (!en) begin
         coll_flag_q <= 1'b0;
      end else if (coll) begin
         coll_flag_q <= 1'b1;
      end
   end

   // start and stop seen: whichever condition came last
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p_q <= 1'b0;
         s_q <= 1'b0;
      end else if (start_det | stop_det) begin
         p_q <= stop_det;
         s_q <= start_det;
      end
   end

   // data-versus-address and direction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         da_q <= 1'b0;
         rw_q <= 1'b0;
      end else begin
         if (addr_take) begin
            da_q <= 1'b0;
            rw_q <= a10 ? rw_q : rx_byte[0];
         end else if (rx_store) begin
            da_q <= 1'b1;
         end else if (tx_full_q && mst_q == M_DONE) begin
            da_q <= 1'b1;
         end
         // ten-bit header byte carries the direction
         if (hi_take) begin
            rw_q <= rx_byte[0];
         end
      end
   end

   // receive holding register; store wins over a same-cycle read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q <= 8'h00;
         rx_full_q <= 1'b0;
      end else if (rx_store) begin
         rx_q <= rx_byte;
         rx_full_q <= 1'b1;
      end else if (rx_rd) begin
         rx_full_q <= 1'b0;
      end
   end

   // transmit full
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_full_q <= 1'b0;
      end else if (tx_take) begin
         tx_full_q <= 1'b1;
      end else if (mst_q == M_DONE || (slave_tx && byte_end)) begin
         tx_full_q <= 1'b0;
      end
   end

   // interrupt flags and enables
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 3'h0;
         irqen_q <= 3'h0;
      end else begin
         if (wr_irq) begin
            irq_q <= irq_q & ~pwdata[2:0];
            irqen_q <= pwdata[6:4];
         end
         // events set flags regardless of irqen_q; set wins over clear
         if (mst_q == M_DONE || coll) begin
            irq_q[0] <= 1'b1;
         end
         if ((start_det & ctrl_q[`I2CS_CTRL_START_IRQ_EN]) | (stop_det & ctrl_q[`I2CS_CTRL_PCIE])
             | (byte_end & (addressed_q | match7 | match10))) begin
            irq_q[1] <= 1'b1;
         end
         if (coll) begin
            irq_q[2] <= 1'b1;
         end
      end
   end

   // slave receiver, listens even while master runs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q <= 8'h00;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         addressed_q <= 1'b0;
         addr_hi_q <= 2'h0;
         first_q <= 1'b0;
      end else if (!en || stop_det) begin
         bit_q <= 4'h0;
         addressed_q <= 1'b0;
         first_q <= 1'b0;
      end else if (start_det) begin
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         first_q <= 1'b1;
         addressed_q <= 1'b0;
      end else if (first_q) begin
         if (scl_rise) begin
            sh_q <= sh_next;
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
         end
         if (byte_end) begin
            if (match7 || match10)
               addressed_q <= 1'b1;
            if (a10 && byte_q == 2'h0 && hi_ok)
               addr_hi_q <= rx_byte[2:1];
            byte_q <= (byte_q == 2'h3) ? 2'h3 : byte_q + 2'h1;
         end
      end
   end

   // slave acknowledge: data held low from the eighth fall to the ninth fall
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slave_ack_q <= 1'b0;
      end else if (!en || start_det || stop_det) begin
         slave_ack_q <= 1'b0;
      end else if (byte_end && ((!addressed_q && (match7 || match10 || hi_take)) || (addressed_q && !rw_q))) begin
         slave_ack_q <= 1'b1;
      end else if (scl_fall && bit_q == 4'h0) begin
         slave_ack_q <= 1'b0;
      end
   end

   // master: start condition, then byte shift on tx load
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mst_q <= M_IDLE;
         tick_q <= 8'h00;
         msh_q <= 8'h00;
         mbit_q <= 4'h0;
         mdrive_q <= 1'b0;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end else if (!en || coll) begin
         mst_q <= M_IDLE;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
         mdrive_q <= 1'b0;
      end else begin
         tick_q <= (tick_q == 8'h00) ? `I2CS_BIT_TICKS : tick_q - 8'h01;
         case (mst_q)
            M_IDLE: begin
               mbit_q <= 4'h0;
               if (ctrl_q[`I2CS_CTRL_START_REQ]) begin
                  mst_q <= M_START;
                  tick_q <= `I2CS_BIT_TICKS;
                  sda_oe_q <= 1'b1;
               end else if (tx_wr) begin
                  mst_q <= M_BIT_LO;
                  msh_q <= pwdata[7:0];
                  mdrive_q <= 1'b1;
                  tick_q <= `I2CS_BIT_TICKS;
               end
            end
            M_START: if (tick_q == 8'h00) begin
               scl_oe_q <= 1'b1;
               mst_q <= M_DONE;
            end
            M_BIT_LO: if (tick_q == 8'h00) begin
               scl_oe_q <= 1'b0;
               mst_q <= M_BIT_HI;
            end else begin
               scl_oe_q <= 1'b1;
               sda_oe_q <= (mbit_q < 4'h8) & ~msh_q[7];
            end
            M_BIT_HI: if (tick_q == 8'h00 && scl) begin
               msh_q <= {msh_q[6:0], sda};
               mbit_q <= mbit_q + 4'h1;
               mst_q <= (mbit_q == 4'h8) ? M_DONE : M_BIT_LO;
            end
            M_DONE: begin
               mdrive_q <= 1'b0;
               mst_q <= M_IDLE;
               mbit_q <= 4'hF;
            end
            default: mst_q <= M_IDLE;
         endcase
      end
   end

   // apb: zero wait states, no error response
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         serial_clock_pin_o <= 1'b0;
         serial_data_pin_o <= 1'b0;
         serial_clock_pin_oe <= 1'b0;
         serial_data_pin_oe <= 1'b0;
         master_event_irq <= 1'b0;
         slave_event_irq <= 1'b0;
         collision_irq <= 1'b0;
         current_source_enable <= 1'b0;
         current_output_onehot <= 4'h0;
         current_calibration <= 6'h00;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         case (paddr)
            `I2CS_OFF_CTRL: prdata <= {16'h0000, ctrl_q};
            `I2CS_OFF_STAT: prdata <= {21'h0, coll_flag_q, 4'h0, da_q, p_q, s_q, rw_q, rx_full_q, tx_full_q};
            `I2CS_OFF_MASK: prdata <= {16'h0000, mask_q};
            `I2CS_OFF_ISRC: prdata <= {16'h0000, isrc_q};
            `I2CS_OFF_TX: prdata <= {24'h000000, tx_q};
            `I2CS_OFF_RX: prdata <= {24'h000000, rx_q};
            `I2CS_OFF_ADDR: prdata <= {22'h0, own_addr_q};
            `I2CS_OFF_IRQ: prdata <= {25'h0, irqen_q, 1'b0, irq_q};
            default: prdata <= 32'h00000000;
         endcase
         // pins owned only while enabled and not preempted
         serial_clock_pin_oe <= en & ~pins_preempted & scl_oe_q;
         serial_data_pin_oe <= en & ~pins_preempted & (sda_oe_q | slave_ack_q);
         master_event_irq <= irq_q[0] & irqen_q[0];
         slave_event_irq <= irq_q[1] & irqen_q[1];
         collision_irq <= irq_q[2] & irqen_q[2];
         current_source_enable <= isrc_q[`I2CS_ISRC_EN];
         case (isrc_q[10:8])
            3'h1: current_output_onehot <= 4'h1;
            3'h2: current_output_onehot <= 4'h2;
            3'h3: current_output_onehot <= 4'h4;
            3'h4: current_output_onehot <= 4'h8;
            default: current_output_onehot <= 4'h0;
         endcase
         current_calibration <= isrc_q[5:0];
      end
   end
endmodule
`default_nettype wire

// ### sim/i2cs_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2cs_map.vh"
module i2cs_core_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe,
   input wire logic serial_data_pin_o,
   input wire logic serial_data_pin_oe,
   input wire logic pins_preempted,
   input wire logic slave_event_irq,
   input wire logic current_source_enable,
   input wire logic [3:0] current_output_onehot,
   input wire logic [5:0] current_calibration
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic rd = psel && penable && !pwrite;
   wire logic isw = psel && penable && pwrite && paddr == `I2CS_OFF_ISRC;
   chk_ready_access: assert property (psel && penable |-> pready)
      else $error("pready missing in access cycle");
   chk_ready_only: assert property (pready |-> psel && penable)
      else $error("pready outside access cycle");
   chk_no_slverr: assert property (!pslverr) else $error("pslverr raised");
   chk_open_drain: assert property (!serial_clock_pin_o && !serial_data_pin_o)
      else $error("bus pin driven high");
   chk_pin_preempt: assert property (pins_preempted [*2] |-> !serial_clock_pin_oe && !serial_data_pin_oe)
      else $error("pins driven while preempted");
   chk_isrc_take: assert property (isw |-> ##2 current_source_enable == $past(pwdata[15], 2) && current_calibration == $past(pwdata[5:0], 2))
      else $error("current source fields not taken");
   chk_sel_decode: assert property (isw |-> ##2 current_output_onehot ==
      (($past(pwdata[10:8], 2) inside {[1:4]}) ? 4'h1 << ($past(pwdata[10:8], 2) - 3'h1) : 4'h0))
      else $error("output select decode wrong");
   chk_sel_onehot: assert property ($onehot0(current_output_onehot))
      else $error("several current outputs selected");
   chk_unmapped_zero: assert property (rd && paddr == 12'h020 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   chk_mask_bits: assert property (rd && paddr == `I2CS_OFF_MASK |-> prdata[15:10] == 6'h0)
      else $error("mask unused bits set");
   cover property (isw);
   cover property ($rose(slave_event_irq));
   cover property (pins_preempted [*2]);
endmodule
bind i2cs_core i2cs_core_asserts u_chk (.*);
`default_nettype wire

// ### sim/i2cs_bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
module i2cs_bus_partner (
   output logic scl_pull,
   output logic sda_pull,
   input wire logic sda
);
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // 40 ns halves give the 80 ns link period; clock stands still between frames
   task automatic start;
      begin
         sda_pull = 1'b1;
         #40 scl_pull = 1'b1;
         #40;
      end
   endtask
   task automatic stop;
      begin
         sda_pull = 1'b1;
         #40 scl_pull = 1'b0;
         #40 sda_pull = 1'b0;
         #40;
      end
   endtask
   // ninth pass releases data and samples the acknowledge
   task automatic put_byte(input logic [7:0] b, output logic ack);
      begin
         for (int i = 7; i >= -1; i--) begin
            sda_pull = (i >= 0) ? !b[i] : 1'b0;
            #20 scl_pull = 1'b0;
            #20 ack = sda;
            #20 scl_pull = 1'b1;
            #20;
         end
      end
   endtask
endmodule
`default_nettype wire

// ### sim/tb_i2cs_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2cs_map.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_i2cs_core;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pins_preempted = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, serial_clock_pin_o, serial_clock_pin_oe, serial_data_pin_o, serial_data_pin_oe;
   wire logic master_event_irq, slave_event_irq, collision_irq, current_source_enable;
   wire logic [3:0] current_output_onehot;
   wire logic [5:0] current_calibration;
   wire logic scl_pull, sda_pull;
   // pull-ups: a line is high unless some party pulls it
   wire logic serial_clock_pin_i = !(serial_clock_pin_oe || scl_pull);
   wire logic serial_data_pin_i = !(serial_data_pin_oe || sda_pull);
   int n_errors = 0, comparisons = 0, k;
   logic [31:0] r;
   logic ack;
   i2cs_core dut (.*);
   i2cs_bus_partner far (.scl_pull(scl_pull), .sda_pull(sda_pull), .sda(serial_data_pin_i));
   task automatic complete_run;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, n_errors);
         if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do begin
            @(posedge pclk);
            n++;
         end while (pready !== 1'b1 && n < 20);
         r = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
         if (pready !== 1'b1) begin
            n_errors++;
            complete_run;
         end
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         `CHK(r, e)
      end
   endtask
   initial begin
      forever #5 pclk = !pclk;
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rchk(`I2CS_OFF_MASK, 32'h0);
      rchk(`I2CS_OFF_ISRC, 32'h0);
      rchk(`I2CS_OFF_STAT, 32'h0);
      rchk(12'h020, 32'h0);
      for (k = 0; k < 8; k++) begin
         wr(`I2CS_OFF_ISRC, 32'h8000 | (k << 8) | k);
         repeat (2) @(negedge pclk);
         `CHK(current_output_onehot, (k inside {[1:4]}) ? 4'h1 << (k - 1) : 4'h0)
         `CHK({current_source_enable, current_calibration}, {1'b1, k[5:0]})
      end
      wr(`I2CS_OFF_ISRC, 32'hFFFFFFFF);
      rchk(`I2CS_OFF_ISRC, 32'h873F);
      wr(`I2CS_OFF_MASK, 32'hFFFFFFFF);
      rchk(`I2CS_OFF_MASK, 32'h3FF);
      $display("test registers done");
      wr(`I2CS_OFF_ADDR, 32'h50);
      wr(`I2CS_OFF_MASK, 32'h1);
      wr(`I2CS_OFF_IRQ, 32'h70);
      wr(`I2CS_OFF_CTRL, 32'h8060);
      @(negedge pclk);
      `CHK({serial_clock_pin_oe, serial_data_pin_oe}, 2'b00)
      far.start;
      rchk(`I2CS_OFF_STAT, 32'h8);
      `CHK(slave_event_irq, 1'b1)
      wr(`I2CS_OFF_IRQ, 32'h77);
      far.put_byte(8'hA2, ack);
      `CHK(ack, 1'b0)
      rchk(`I2CS_OFF_STAT, 32'h8);
      `CHK(slave_event_irq, 1'b1)
      far.put_byte(8'h3C, ack);
      rchk(`I2CS_OFF_STAT, 32'h2A);
      rchk(`I2CS_OFF_RX, 32'h3C);
      rchk(`I2CS_OFF_STAT, 32'h28);
      far.stop;
      rchk(`I2CS_OFF_STAT, 32'h30);
      wr(`I2CS_OFF_MASK, 32'h0);
      far.start;
      far.put_byte(8'hA2, ack);
      `CHK(ack, 1'b1)
      far.stop;
      $display("test slave done");
      `CHK(serial_clock_pin_oe, 1'b0)
      wr(`I2CS_OFF_IRQ, 32'h77);
      wr(`I2CS_OFF_CTRL, 32'h8061);
      for (k = 0; k < 1000 && master_event_irq !== 1'b1; k++) @(posedge pclk);
      `CHK(master_event_irq, 1'b1)
      if (master_event_irq !== 1'b1) complete_run;
      pins_preempted <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK({serial_clock_pin_oe, serial_data_pin_oe}, 2'b00)
      pins_preempted <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK({serial_clock_pin_oe, serial_data_pin_oe}, 2'b11)
      wr(`I2CS_OFF_TX, 32'h55);
      apb(1'b0, `I2CS_OFF_STAT, 32'h0);
      `CHK(r[0], 1'b1)
      for (k = 0; k < 400 && r[0] !== 1'b0; k++) apb(1'b0, `I2CS_OFF_STAT, 32'h0);
      `CHK(r[0], 1'b0)
      if (r[0] !== 1'b0) complete_run;
      wr(`I2CS_OFF_CTRL, 32'h0);
      repeat (3) @(posedge pclk);
      `CHK({serial_clock_pin_oe, serial_data_pin_oe}, 2'b00)
      pins_preempted <= 1'b1;
      repeat (4) @(posedge pclk);
      pins_preempted <= 1'b0;
      $display("test master done");
      complete_run;
   end
endmodule
`default_nettype wire
